/* File: iod_pkg.sv */
// Constants and types shared by the I/O element cells and the memory data lane
// What this block does
// - Column block takes 28 array signals: data, oe, two CEs, clock, aclr, sclr per element.
// - Each element offers two input paths, combinational or from the input register.
// - Six dedicated low-skew element clock lines feed the element registers.
// - Each element picks its own oe, CE and clock sources; aclr source is picked for the whole block.
// - Input register has clock and enable independent of output registers.
// - Output and OE registers share one clock source and one enable.
// - All three registers share sclr and aclr, each may ignore either.
// - With input register used, other path stays combinational with one delay setting.
// - Block shares one clear source; element chooses preset or clear, not both.
// - Registers start at programmed value; low responds to clear, high to preset.
// - All registers of one element use the same preset or clear signal.
// - Data group is one strobe, one mask and up to nine data pins.
// - Nine-bit group also works as eight-bit group.
// - Parity allowed, one bit per eight data bits, on any data pin.
// - Mask pin low marks write data valid, high masks it.
// - Strobe or read clock input is delayed programmably to centre in data window.
// - Delayed strobe clocks the registers capturing read data.
// - System clock times strobes; write clock lags a quarter period, times data.
// - Lane rate stays within 167 MHz clock and 333 Mbps data.
package iod_pkg;
  localparam int ADDR_W   = 8;
  localparam int N_ELEM   = 4;
  localparam int N_IOCLK  = 6;
  localparam int LANE_W   = 9;
  localparam int DLY_TAPS = 16;
  localparam int CLK_MHZ  = 125;
  localparam int PH_N     = 4;
  localparam int MAX_MHZ  = 167;
  localparam int MAX_MBPS = 333;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ECFG0 = 8'h10;

  // Control register fields
  localparam int CTRL_W   = 14;
  localparam int F_LANE   = 0;
  localparam int F_BIDIR  = 1;
  localparam int F_WIDE9  = 2;
  localparam int F_PAREN  = 3;
  localparam int F_PARPOS = 4;
  localparam int F_DLY    = 8;
  localparam int F_ACSRC  = 12;

  // Status register fields
  localparam int S_PARERR = 0;
  localparam int S_DRV    = 1;
  localparam int S_PEND   = 2;
  localparam int S_RATEOK = 3;

  // Element configuration fields
  localparam int ECFG_W  = 19;
  localparam int F_INREG = 0;
  localparam int F_ICLK  = 1;
  localparam int F_OCLK  = 4;
  localparam int F_ICE   = 7;
  localparam int F_OCE   = 8;
  localparam int F_OEON  = 9;
  localparam int F_PUHI  = 10;
  localparam int F_IGNS  = 11;
  localparam int F_IGNA  = 14;
  localparam int F_DLYA  = 17;
  localparam int F_DLYB  = 18;

  // Clock source codes, below CS_ARRAY picks a dedicated line
  localparam logic [2:0] CS_ARRAY = 3'h6;

  // Lane phases of the divided system clock
  localparam logic [1:0] PH_LAUNCH = 2'h0;
  localparam logic [1:0] PH_FALL   = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {REG_NONE, REG_CTRL, REG_STAT, REG_ECFG} iod_reg_t;
endpackage : iod_pkg

/* File: iod_cell.sv */
// One element register with clear, preset and enable handling
`timescale 1ns/10ps
`default_nettype none
module iod_cell (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic init,
  input  wire logic tick,
  input  wire logic ce,
  input  wire logic sclr,
  input  wire logic aclr,
  input  wire logic ign_sclr,
  input  wire logic ign_aclr,
  input  wire logic pu_high,
  // Data
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic q;
  } iod_cell_st_t;

  iod_cell_st_t st_q;
  iod_cell_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (init) begin
      st_d.q = pu_high;
    end else if (aclr && !ign_aclr) begin
      st_d.q = pu_high;
    end else if (tick && sclr && !ign_sclr) begin
      st_d.q = pu_high;
    end else if (tick && ce) begin
      st_d.q = d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.q;
endmodule : iod_cell
`default_nettype wire

/* File: iod_top.sv */
// Column I/O block of four elements plus one DDR memory data lane
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module iod_top #(
  parameter int DQ_W = iod_pkg::LANE_W
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite slave
  input  wire logic [iod_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [iod_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Logic array side of the elements
  input  wire logic [iod_pkg::N_ELEM-1:0]  arr_dout,
  input  wire logic [iod_pkg::N_ELEM-1:0]  arr_oe,
  input  wire logic [iod_pkg::N_ELEM-1:0]  arr_ce_in,
  input  wire logic [iod_pkg::N_ELEM-1:0]  arr_ce_out,
  input  wire logic [iod_pkg::N_ELEM-1:0]  arr_clk_tick,
  input  wire logic [iod_pkg::N_ELEM-1:0]  arr_aclr,
  input  wire logic [iod_pkg::N_ELEM-1:0]  arr_sclr,
  input  wire logic [iod_pkg::N_IOCLK-1:0] ioclk_tick,
  output logic [iod_pkg::N_ELEM-1:0]       arr_din_a,
  output logic [iod_pkg::N_ELEM-1:0]       arr_din_b,
  // Element pins
  input  wire logic [iod_pkg::N_ELEM-1:0]  elem_pin_i,
  output logic [iod_pkg::N_ELEM-1:0]       elem_pin_o,
  output logic [iod_pkg::N_ELEM-1:0]       elem_pin_oe,
  // Lane user side
  input  wire logic                        wr_valid,
  output logic                             wr_ready,
  input  wire logic [2*DQ_W-1:0]           wr_data,
  input  wire logic [1:0]                  wr_be,
  output logic                             rd_valid,
  output logic [2*DQ_W-1:0]                rd_data,
  // Lane memory pins
  output logic                             mem_clk_o,
  input  wire logic [DQ_W-1:0]             dq_i,
  output logic [DQ_W-1:0]                  dq_o,
  output logic [DQ_W-1:0]                  dq_oe,
  input  wire logic                        dqs_i,
  output logic                             dqs_o,
  output logic                             dqs_oe,
  output logic                             dm_o
);
  import iod_pkg::*;

  localparam int          LANE_MHZ = CLK_MHZ / PH_N;
  localparam logic        RATE_OK  = (LANE_MHZ <= MAX_MHZ) && (2 * LANE_MHZ <= MAX_MBPS);

  typedef struct packed {
    logic                              aw_got;
    logic [ADDR_W-1:0]                 aw_addr;
    logic                              w_got;
    logic [31:0]                       w_data;
    logic [3:0]                        w_strb;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              rvalid;
    logic [31:0]                       rdata;
    logic [1:0]                        rresp;
    logic [CTRL_W-1:0]                 ctrl;
    logic [N_ELEM-1:0][ECFG_W-1:0]     ecfg;
    logic [N_ELEM-1:0]                 init;
    logic                              par_err;
    logic [N_ELEM-1:0]                 pin_s1;
    logic [N_ELEM-1:0]                 pin_s2;
    logic [N_ELEM-1:0]                 pin_d;
    logic [DQ_W-1:0]                   dq_s1;
    logic [DQ_W-1:0]                   dq_s2;
    logic                              dqs_s1;
    logic                              dqs_echo;
    logic [DLY_TAPS-1:0]               dqs_chain;
    logic                              dqs_prev;
    logic [DQ_W-1:0]                   rise_cap;
    logic                              rd_valid;
    logic [2*DQ_W-1:0]                 rd_data;
    logic [1:0]                        ph;
    logic                              sysclk;
    logic                              wpend;
    logic [2*DQ_W-1:0]                 wbuf;
    logic [1:0]                        wbe;
    logic [DQ_W-1:0]                   wfall;
    logic                              wfall_be;
    logic                              drv;
    logic [DQ_W-1:0]                   dq_o;
    logic                              dm;
    logic                              dqs_o;
    logic                              dqs_oe;
  } iod_st_t;

  iod_st_t st_q;
  iod_st_t st_d;

  function automatic iod_reg_t dec_reg(input logic [ADDR_W-1:0] a);
    iod_reg_t r;
    r = REG_NONE;
    if (a == OFF_CTRL) r = REG_CTRL;
    else if (a == OFF_STAT) r = REG_STAT;
    else if (a >= OFF_ECFG0 && a < OFF_ECFG0 + ADDR_W'(4 * N_ELEM) && a[1:0] == 2'h0) r = REG_ECFG;
    return r;
  endfunction : dec_reg

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic clk_pick(input logic [2:0] sel, input logic [N_IOCLK-1:0] ioc, input logic arr);
    logic r;
    r = 1'h1;
    if (sel < CS_ARRAY) r = ioc[sel];
    else if (sel == CS_ARRAY) r = arr;
    return r;
  endfunction : clk_pick

  // Place parity of eight data bits on the chosen pin, data fills the rest
  function automatic logic [DQ_W-1:0] par_ins(input logic [DQ_W-1:0] d, input logic [3:0] pos);
    logic [DQ_W-1:0] r;
    int              j;
    r = '0;
    j = 0;
    for (int i = 0; i < DQ_W; i++) begin
      if (i == int'(pos)) begin
        r[i] = ^d[DQ_W-2:0];
      end else begin
        r[i] = d[j];
        j++;
      end
    end
    return r;
  endfunction : par_ins

  logic                 wide9;
  logic                 par_on;
  logic                 shared_aclr;
  logic                 dly_stb;
  logic [N_ELEM-1:0]    in_q;
  logic [N_ELEM-1:0]    out_q;
  logic [N_ELEM-1:0]    oe_q;
  iod_reg_t             wsel;
  iod_reg_t             rsel;

  assign wide9       = st_q.ctrl[F_WIDE9];
  assign par_on      = st_q.ctrl[F_PAREN] && wide9;
  assign shared_aclr = arr_aclr[st_q.ctrl[F_ACSRC +: 2]];
  assign dly_stb     = st_q.dqs_chain[st_q.ctrl[F_DLY +: 4]];
  assign wsel        = dec_reg(st_q.aw_addr);
  assign rsel        = dec_reg(araddr);

  assign awready  = !st_q.aw_got && !st_q.bvalid;
  assign wready   = !st_q.w_got && !st_q.bvalid;
  assign arready  = !st_q.rvalid;
  assign wr_ready = st_q.ctrl[F_LANE] && !st_q.wpend;

  // Elements: clock selection, three register cells, two input paths
  for (genvar e = 0; e < N_ELEM; e++) begin : g_elem
    logic [ECFG_W-1:0] cfg;
    logic              in_tick;
    logic              out_tick;
    logic              path_a;
    logic              path_b;
    assign cfg      = st_q.ecfg[e];
    assign in_tick  = clk_pick(cfg[F_ICLK +: 3], ioclk_tick, arr_clk_tick[e]);
    assign out_tick = clk_pick(cfg[F_OCLK +: 3], ioclk_tick, arr_clk_tick[e]);
    assign path_a   = cfg[F_DLYA] ? st_q.pin_d[e] : st_q.pin_s2[e];
    // One delay setting applies once the register takes a path
    assign path_b   = (cfg[F_INREG] ? cfg[F_DLYA] : cfg[F_DLYB]) ? st_q.pin_d[e] : st_q.pin_s2[e];
    assign arr_din_a[e]   = cfg[F_INREG] ? in_q[e] : path_a;
    assign arr_din_b[e]   = path_b;
    assign elem_pin_o[e]  = out_q[e];
    assign elem_pin_oe[e] = oe_q[e];

    iod_cell u_in (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .init     (st_q.init[e]),
      .tick     (in_tick),
      .ce       (!cfg[F_ICE] || arr_ce_in[e]),
      .sclr     (arr_sclr[e]),
      .aclr     (shared_aclr),
      .ign_sclr (cfg[F_IGNS]),
      .ign_aclr (cfg[F_IGNA]),
      .pu_high  (cfg[F_PUHI]),
      .d        (path_a),
      .q        (in_q[e])
    );
    iod_cell u_out (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .init     (st_q.init[e]),
      .tick     (out_tick),
      .ce       (!cfg[F_OCE] || arr_ce_out[e]),
      .sclr     (arr_sclr[e]),
      .aclr     (shared_aclr),
      .ign_sclr (cfg[F_IGNS+1]),
      .ign_aclr (cfg[F_IGNA+1]),
      .pu_high  (cfg[F_PUHI]),
      .d        (arr_dout[e]),
      .q        (out_q[e])
    );
    iod_cell u_oe (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .init     (st_q.init[e]),
      .tick     (out_tick),
      .ce       (!cfg[F_OCE] || arr_ce_out[e]),
      .sclr     (arr_sclr[e]),
      .aclr     (shared_aclr),
      .ign_sclr (cfg[F_IGNS+2]),
      .ign_aclr (cfg[F_IGNA+2]),
      .pu_high  (cfg[F_PUHI]),
      .d        (cfg[F_OEON] || arr_oe[e]),
      .q        (oe_q[e])
    );
  end

  always_comb begin
    st_d          = st_q;
    st_d.init     = '0;
    st_d.rd_valid = 1'h0;

    // Bus write: address and data in either order, answer once both are in
    if (awvalid && awready) begin
      st_d.aw_got  = 1'h1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_d.w_got  = 1'h1;
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
    end
    if (st_q.bvalid && bready) st_d.bvalid = 1'h0;
    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got = 1'h0;
      st_d.w_got  = 1'h0;
      st_d.bvalid = 1'h1;
      st_d.bresp  = RESP_OKAY;
      case (wsel)
        REG_CTRL: st_d.ctrl = CTRL_W'(merge(32'(st_q.ctrl), st_q.w_data, st_q.w_strb));
        REG_STAT: begin
          if (st_q.w_strb[0] && st_q.w_data[S_PARERR]) st_d.par_err = 1'h0;
        end
        REG_ECFG: begin
          st_d.ecfg[st_q.aw_addr[3:2]] =
            ECFG_W'(merge(32'(st_q.ecfg[st_q.aw_addr[3:2]]), st_q.w_data, st_q.w_strb));
          st_d.init[st_q.aw_addr[3:2]] = 1'h1;
        end
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end

    // Bus read
    if (st_q.rvalid && rready) st_d.rvalid = 1'h0;
    if (arvalid && arready) begin
      st_d.rvalid = 1'h1;
      st_d.rdata  = '0;
      st_d.rresp  = RESP_OKAY;
      case (rsel)
        REG_CTRL: st_d.rdata = 32'(st_q.ctrl);
        REG_STAT: st_d.rdata = 32'({RATE_OK, st_q.wpend, st_q.drv, st_q.par_err});
        REG_ECFG: st_d.rdata = 32'(st_q.ecfg[araddr[3:2]]);
        default:  st_d.rresp = RESP_SLVERR;
      endcase
    end

    // Pin synchronisers
    st_d.pin_s1    = elem_pin_i;
    st_d.pin_s2    = st_q.pin_s1;
    st_d.pin_d     = st_q.pin_s2;
    st_d.dq_s1     = dq_i;
    st_d.dq_s2     = st_q.dq_s1;
    st_d.dqs_s1    = dqs_i;
    st_d.dqs_chain = {st_q.dqs_chain[DLY_TAPS-2:0], st_q.dqs_s1};
    st_d.dqs_prev  = dly_stb;
    // Own strobe echoes back through the pin; keep it out of the delay line
    st_d.dqs_echo  = st_q.dqs_oe;
    if (st_q.dqs_oe || st_q.dqs_echo) st_d.dqs_chain = '0;

    // Read capture on delayed strobe edges, rising half then falling half
    if (st_q.ctrl[F_LANE] && !st_q.drv) begin
      if (dly_stb && !st_q.dqs_prev) begin
        st_d.rise_cap = st_q.dq_s2 & {wide9, {(DQ_W-1){1'h1}}};
      end
      if (!dly_stb && st_q.dqs_prev) begin
        st_d.rd_valid = 1'h1;
        st_d.rd_data  = {st_q.dq_s2 & {wide9, {(DQ_W-1){1'h1}}}, st_q.rise_cap};
        if (par_on && ((^st_q.dq_s2) || (^st_q.rise_cap))) st_d.par_err = 1'h1;
      end
    end

    // Divided system clock; write clock lags it by one phase of four
    // Parked one phase early so the first clock high after enable is full length
    st_d.ph     = st_q.ctrl[F_LANE] ? st_q.ph + 2'h1 : PH_LAUNCH - 2'h1;
    st_d.sysclk = st_q.ctrl[F_LANE] && !st_d.ph[1];

    if (st_q.ph == PH_LAUNCH) begin
      if (st_q.wpend) begin
        st_d.wpend    = 1'h0;
        st_d.drv      = 1'h1;
        st_d.dq_o     = st_q.wbuf[DQ_W-1:0];
        st_d.dm       = !st_q.wbe[0];
        st_d.wfall    = st_q.wbuf[2*DQ_W-1:DQ_W];
        st_d.wfall_be = st_q.wbe[1];
      end else begin
        st_d.drv = 1'h0;
        st_d.dm  = 1'h1;
      end
    end else if (st_q.ph == PH_FALL && st_q.drv) begin
      st_d.dq_o = st_q.wfall;
      st_d.dm   = !st_q.wfall_be;
    end
    st_d.dqs_o  = st_d.sysclk && st_d.drv;
    st_d.dqs_oe = st_d.drv && st_q.ctrl[F_BIDIR];

    // Write load, parity inserted per half when enabled
    if (wr_valid && wr_ready) begin
      st_d.wpend = 1'h1;
      st_d.wbe   = wr_be;
      st_d.wbuf  = wr_data;
      if (par_on) begin
        st_d.wbuf = {par_ins(wr_data[2*DQ_W-1:DQ_W], st_q.ctrl[F_PARPOS +: 4]),
                     par_ins(wr_data[DQ_W-1:0], st_q.ctrl[F_PARPOS +: 4])};
      end
    end

    if (!st_q.ctrl[F_LANE]) begin
      st_d.wpend = 1'h0;
      st_d.drv   = 1'h0;
      st_d.dm    = 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= '0;
      st_q.dm <= 1'h1;
    end else begin
      st_q <= st_d;
    end
  end

  assign bvalid    = st_q.bvalid;
  assign bresp     = st_q.bresp;
  assign rvalid    = st_q.rvalid;
  assign rdata     = st_q.rdata;
  assign rresp     = st_q.rresp;
  assign rd_valid  = st_q.rd_valid;
  assign rd_data   = st_q.rd_data;
  assign mem_clk_o = st_q.sysclk;
  assign dq_o      = st_q.dq_o;
  // Top pin of the group floats in eight-bit use
  assign dq_oe     = {st_q.drv && wide9, {(DQ_W-1){st_q.drv}}};
  assign dqs_o     = st_q.dqs_o;
  assign dqs_oe    = st_q.dqs_oe;
  assign dm_o      = st_q.dm;
endmodule : iod_top
`default_nettype wire

/* File: iod_top_chk.sv */
// Port assertions for the I/O block and its memory lane
`timescale 1ns/10ps
`default_nettype none
module iod_top_chk #(
  parameter int DQ_W = 9
) (
  // Clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // Register bus
  input wire logic            awvalid,
  input wire logic            awready,
  input wire logic            wvalid,
  input wire logic            wready,
  input wire logic            bvalid,
  input wire logic            arvalid,
  input wire logic            arready,
  input wire logic            rvalid,
  input wire logic            rready,
  // Lane
  input wire logic            rd_valid,
  input wire logic            mem_clk_o,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic [DQ_W-1:0] dq_oe,
  input wire logic            dqs_o,
  input wire logic            dqs_oe,
  input wire logic            dm_o
);
  import iod_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wr_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response missing");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  rd_resp_a: assert property (arvalid && arready |=> rvalid ##1 !rvalid)
    else $error("read response not one cycle later");
  rd_pulse_a: assert property (rd_valid |=> !rd_valid)
    else $error("read word pulse too long");
  strobe_clk_a: assert property (dqs_oe |-> dqs_o == mem_clk_o && dq_oe[0])
    else $error("strobe not following system clock");
  group_oe_a: assert property ((dq_oe[7:0] == 8'h00 || dq_oe[7:0] == 8'hff) && (!dq_oe[8] || dq_oe[0]))
    else $error("data group enables split");
  half_hold_a: assert property (dq_oe[0] && $past(dq_oe[0]) && $changed(mem_clk_o)
    |-> $stable(dq_o) && $stable(dm_o))
    else $error("data or mask moved inside a half");
  mclk_high_a: assert property ($rose(mem_clk_o) |=> mem_clk_o ##1 !mem_clk_o)
    else $error("system clock high time wrong");

  wr_c: cover property (bvalid);
  rd_c: cover property (rd_valid);
  dqs_c: cover property (dqs_oe);
endmodule : iod_top_chk
bind iod_top iod_top_chk #(.DQ_W(DQ_W)) iod_top_chk_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .arvalid, .arready, .rvalid, .rready, .rd_valid, .mem_clk_o, .dq_o, .dq_oe, .dqs_o, .dqs_oe, .dm_o);
`default_nettype wire

/* File: iod_mem_model.sv */
// Behavioural memory at the far side of the data lane
`timescale 1ns/10ps
`default_nettype none
module iod_mem_model (
  // Clock
  input wire logic        aclk,
  // Pins from the lane
  input wire logic        mem_clk_o,
  input wire logic        dm_o,
  input wire logic [8:0]  dq_o,
  input wire logic [8:0]  dq_oe,
  // Pins toward the lane
  output logic [8:0]      mem_dq,
  output logic            mem_dqs
);
  logic [8:0] last = 9'h000;
  logic       drv = 1'b0;
  logic [1:0] mc = 2'h0;
  logic [8:0] got[$];
  // Released bus shows the inverse, never a stale copy
  assign mem_dq = drv ? last : ~last;
  initial mem_dqs = 1'b0;
  // Sample mid-window, one cycle after each clock edge; masked halves dropped
  always @(posedge aclk) begin
    mc <= {mc[0], mem_clk_o};
    if (dq_oe[0] && !dm_o && mem_clk_o == mc[0] && mc[0] != mc[1]) begin
      got.push_back(dq_o);
    end
  end
  // Read burst: strobe rises with the low half and falls three cycles after the high half starts; device must centre them
  task automatic burst(input logic [8:0] lo, input logic [8:0] hi);
    last <= lo;
    drv <= 1'b1;
    mem_dqs <= 1'b1;
    repeat (6) @(posedge aclk);
    last <= hi;
    repeat (3) @(posedge aclk);
    mem_dqs <= 1'b0;
    repeat (6) @(posedge aclk);
    drv <= 1'b0;
  endtask : burst
endmodule : iod_mem_model
`default_nettype wire

/* File: iod_top_test.sv */
// Self-checking bench for the I/O block and memory lane
`timescale 1ns/10ps
`default_nettype none
module iod_top_test;
  import iod_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1, wr_valid = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [3:0] arr_dout = 0, arr_oe = 0, arr_ce_in = 0, arr_ce_out = 0, arr_aclr = 0, arr_sclr = 0, arr_clk_tick = 0;
  logic [3:0] elem_pin_i = 0, arr_din_a, arr_din_b, elem_pin_o, elem_pin_oe;
  logic [5:0] ioclk_tick = 0;
  logic [17:0] wr_data = 0, rd_data, rdd;
  logic [1:0] wr_be = 0, bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, rd_valid, wr_ready, mem_clk_o, dqs_o, dqs_oe, dm_o, mem_dqs;
  logic [8:0] dq_o, dq_oe, mem_dq;
  int err_count = 0, checks_done = 0;
  // Shared pins resolved from both drivers
  wire logic [8:0] dq_i = (dq_oe & dq_o) | (~dq_oe & mem_dq);
  wire logic dqs_i = dqs_oe ? dqs_o : mem_dqs;

  always #4 aclk = ~aclk;

  iod_top iod_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .arr_dout, .arr_oe,
    .arr_ce_in, .arr_ce_out, .arr_clk_tick, .arr_aclr, .arr_sclr, .ioclk_tick, .arr_din_a, .arr_din_b,
    .elem_pin_i, .elem_pin_o, .elem_pin_oe, .wr_valid, .wr_ready, .wr_data, .wr_be, .rd_valid, .rd_data,
    .mem_clk_o, .dq_i, .dq_o, .dq_oe, .dqs_i, .dqs_o, .dqs_oe, .dm_o);
  iod_mem_model iod_mem_model_i (.aclk, .mem_clk_o, .dm_o, .dq_o, .dq_oe, .mem_dq, .mem_dqs);

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready === 1'b1) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    do step(1); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do step(1); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(1); while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
  endtask : rd

  // Two words back to back, valid held between them
  task automatic lane_send(input logic [17:0] d0, input logic [1:0] b0, input logic [17:0] d1, input logic [1:0] b1);
    for (int k = 0; k < 2; k++) begin
      wr_data <= k == 0 ? d0 : d1;
      wr_be <= k == 0 ? b0 : b1;
      wr_valid <= 1'b1;
      do step(1); while (wr_ready !== 1'b1);
    end
    wr_valid <= 1'b0;
  endtask : lane_send

  task automatic wait_rd;
    do step(1); while (rd_valid !== 1'b1);
    rdd = rd_data;
  endtask : wait_rd

  function automatic logic [8:0] spread(input logic [7:0] d, input int p);
    logic [8:0] r;
    int j;
    j = 0;
    for (int i = 0; i < 9; i++) begin
      if (i == p) r[i] = ^d;
      else begin
        r[i] = d[j];
        j++;
      end
    end
    return r;
  endfunction : spread

  initial begin
    #100000;
    err_count++;
    test_done;
  end

  initial begin
    step(6);
    aresetn <= 1'b1;
    rd(OFF_CTRL);
    chk(rdv, 32'h0);
    rd(OFF_STAT);
    chk(rdv, 32'h8);
    rd(8'h08);
    chk(resp, RESP_SLVERR);
    wr(8'h0c, 32'h1);
    chk(resp, RESP_SLVERR);
    // Element 0, output side clocked every cycle
    wr(OFF_CTRL, 32'h1000);
    arr_dout <= 4'h1;
    arr_oe <= 4'h1;
    elem_pin_i <= 4'h1;
    wr(OFF_ECFG0, 32'h70);
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0], arr_din_a[0], arr_din_b[0]}, 4'hf);
    arr_sclr <= 4'h1;
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h0);
    arr_sclr <= 4'h0;
    arr_aclr <= 4'h1;
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h3);
    arr_aclr <= 4'h2;
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h0);
    wr(OFF_ECFG0, 32'h8070);
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h2);
    arr_oe <= 4'h0;
    wr(OFF_ECFG0, 32'h470);
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h3);
    arr_aclr <= 4'h0;
    arr_dout <= 4'h0;
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h0);
    // Shared enable, then dedicated clock lines
    arr_dout <= 4'h1;
    arr_oe <= 4'h1;
    wr(OFF_ECFG0, 32'h170);
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h0);
    arr_ce_out <= 4'h1;
    step(3);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h3);
    wr(OFF_ECFG0, 32'h20);
    step(2);
    for (int k = 1; k < 3; k++) begin
      ioclk_tick <= 6'h1 << k;
      step(1);
      ioclk_tick <= 6'h0;
      step(2);
      chk({elem_pin_o[0], elem_pin_oe[0]}, k == 2 ? 2'h3 : 2'h0);
    end
    // Array clock as source, register holds until it ticks
    wr(OFF_ECFG0, 32'h60);
    step(2);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h0);
    arr_clk_tick <= 4'h1;
    step(1);
    arr_clk_tick <= 4'h0;
    step(2);
    chk({elem_pin_o[0], elem_pin_oe[0]}, 2'h3);
    // Input register with its own enable
    wr(OFF_ECFG0, 32'h8f);
    step(4);
    chk({arr_din_a[0], arr_din_b[0]}, 2'h1);
    arr_ce_in <= 4'h1;
    step(4);
    chk({arr_din_a[0], arr_din_b[0]}, 2'h3);
    // Lane writes: masked half never reaches memory
    wr(OFF_CTRL, 32'h207);
    lane_send({9'h1a5, 9'h05a}, 2'h3, {9'h133, 9'h0cc}, 2'h2);
    step(12);
    chk(iod_mem_model_i.got.size(), 3);
    chk(iod_mem_model_i.got.pop_front(), 9'h05a);
    chk(iod_mem_model_i.got.pop_front(), 9'h1a5);
    chk(iod_mem_model_i.got.pop_front(), 9'h133);
    wr(OFF_CTRL, 32'h23f);
    lane_send({9'h001, 9'h0b7}, 2'h3, 18'h0, 2'h0);
    step(12);
    chk(iod_mem_model_i.got.size(), 2);
    chk(iod_mem_model_i.got.pop_front(), spread(8'hb7, 3));
    chk(iod_mem_model_i.got.pop_front(), spread(8'h01, 3));
    // Lane reads through the delayed strobe
    wr(OFF_CTRL, 32'h207);
    fork
      iod_mem_model_i.burst(9'h155, 9'h0aa);
      wait_rd;
    join
    chk(rdd, {9'h0aa, 9'h155});
    wr(OFF_CTRL, 32'h23f);
    fork
      iod_mem_model_i.burst(9'h001, 9'h000);
      wait_rd;
    join
    rd(OFF_STAT);
    chk(rdv[0], 1'h1);
    wr(OFF_STAT, 32'h1);
    rd(OFF_STAT);
    chk(rdv[0], 1'h0);
    test_done;
  end
endmodule : iod_top_test
`default_nettype wire
